// [rtl/tsm_defines.vh]
// Constants for the temperature and supply monitor controller.
// Summary of operation
// - Periodic mode repeats runs every period field times 16 ms; field resets to 0010.
// - Periodic bit resets to 1; when clear, each start gives one run.
// - Writing 1 to start launches the monitor; bit self-clears; writing 0 does nothing.
// - Under-voltage threshold is RW bits 14:12, reset 111.
// - Over-voltage threshold is RW bits 10:8, reset 000.
// - Supply band codes run 000 (above +9%) to 111 (below -16.5%).
// - Over-temperature threshold is RW bits 2:0, reset 111.
// - Temperature codes run 000 (below -40 C) to 111 (above 165 C).
// - Temperature status bits 2:0 are read-only, reset 000, same band code.
// - Supply status reports io_supply_rail band in bits 14:12, read-only.
`ifndef TSM_DEFINES_VH
`define TSM_DEFINES_VH
`define TSM_IDX_PERIOD 12'h0480
`define TSM_IDX_MODE 12'h0481
`define TSM_IDX_THRESH 12'h0482
`define TSM_IDX_TSTAT 12'h0483
`define TSM_IDX_SSTAT 12'h0484
`define TSM_IDX_IRQ_STAT 12'h0490
`define TSM_IDX_IRQ_MASK 12'h0491
`define TSM_RST_PERIOD 4'h2
`define TSM_RST_MODE_HI 14'h0028
`define TSM_RST_THRESH 16'h7007
`define TSM_THRESH_RW_MASK 16'hFFFF
`define TSM_PERIOD_UNIT_MS 16
`define TSM_CLK_HZ 125000000
`define TSM_MS_CYCLES ((`TSM_CLK_HZ / 1000))
`define TSM_SAMPLE_TIMEOUT 8'hFF
`endif

// [rtl/tsm_ctrl.v]
// Temperature and supply monitor control and status block with AHB-Lite slave.
`timescale 1ns/1ns
`default_nettype none
`include "tsm_defines.vh"
module tsm_ctrl #(
  parameter [31:0] MS_CYCLES = `TSM_MS_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output wire sample_req,
  input wire sample_done,
  input wire [2:0] temp_band,
  input wire [2:0] io_supply_rail_band,
  input wire [2:0] core_supply_band,
  output wire [2:0] uv_threshold,
  output wire [2:0] ov_threshold,
  output wire [2:0] ot_threshold,
  output wire irq
);
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_SAMPLE = 2'd2;

  // Analog results come from another timing domain; every bit passes two flops
  // before any logic reads it; each bit of a band is synchronised on its own, so a changing band can be caught half-way.
  wire [9:0] ana_in = {sample_done, temp_band, io_supply_rail_band, core_supply_band};
  wire [9:0] ana_sync;
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_sync
      reg s1_reg;
      reg s2_reg;
      always @(posedge clk) begin
        if (!rst_n) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
        end else begin
          s1_reg <= ana_in[gi];
          s2_reg <= s1_reg;
        end
      end
      assign ana_sync[gi] = s2_reg;
    end
  endgenerate

  // The third flop only keeps the previous synchronised level for the edge.
  reg done_s3_reg;
  always @(posedge clk) begin
    if (!rst_n) begin
      done_s3_reg <= 1'b0;
    end else begin
      done_s3_reg <= ana_sync[9];
    end
  end
  wire done_rise = ana_sync[9] & ~done_s3_reg;
  wire [2:0] temp_sync = ana_sync[8:6];
  wire [2:0] io_sync = ana_sync[5:3];
  wire [2:0] core_sync = ana_sync[2:0];

  // Bus address phase capture.
  reg wr_pend_reg;
  reg [11:0] wr_idx_reg;
  reg [31:0] rdata_reg;
  wire take = hsel & hready & htrans[1];
  wire [11:0] idx = haddr[13:2];

  reg [3:0] period_reg;
  reg [13:0] mode_hi_reg;
  reg periodic_reg;
  reg start_reg;
  reg [15:0] thresh_reg;
  reg [2:0] temp_stat_reg;
  reg [2:0] io_stat_reg;
  reg [2:0] core_stat_reg;
  wire [1:0] irq_stat_bits;
  reg [1:0] irq_mask_reg;
  reg [1:0] state_reg;
  reg [31:0] ms_cnt_reg;
  reg [7:0] per_cnt_reg;
  reg [7:0] to_cnt_reg;

  wire wr_now = wr_pend_reg;
  wire wr_period = wr_now && wr_idx_reg == `TSM_IDX_PERIOD;
  wire wr_mode = wr_now && wr_idx_reg == `TSM_IDX_MODE;
  wire wr_thresh = wr_now && wr_idx_reg == `TSM_IDX_THRESH;
  wire wr_istat = wr_now && wr_idx_reg == `TSM_IDX_IRQ_STAT;
  wire wr_imask = wr_now && wr_idx_reg == `TSM_IDX_IRQ_MASK;
  wire start_wr = wr_mode & hwdata[0];

  // A zero period is invalid; it is run as the shortest one rather than hanging.
  wire [3:0] eff_period = (period_reg == 4'h0) ? 4'h1 : period_reg;
  wire run_done = (state_reg == ST_SAMPLE) & done_rise;
  wire run_timeout = (state_reg == ST_SAMPLE) & (to_cnt_reg == `TSM_SAMPLE_TIMEOUT);
  wire ms_tick = (ms_cnt_reg == MS_CYCLES - 32'd1);
  // Each step of the period field is 16 ms, counted in millisecond ticks.
  wire [7:0] wait_ms = {eff_period, 4'h0};

  // Read multiplexer: reserved bits and unmapped words read as zero.
  reg [31:0] rdata_next;
  always @* begin
    rdata_next = 32'h0000_0000;
    case (idx)
      `TSM_IDX_PERIOD: begin
        rdata_next = {28'h000_0000, period_reg};
      end
      `TSM_IDX_MODE: begin
        rdata_next = {16'h0000, mode_hi_reg, periodic_reg, start_reg};
      end
      `TSM_IDX_THRESH: begin
        rdata_next = {16'h0000, thresh_reg};
      end
      `TSM_IDX_TSTAT: begin
        rdata_next = {29'h0000_0000, temp_stat_reg};
      end
      `TSM_IDX_SSTAT: begin
        rdata_next = {17'h0_0000, io_stat_reg, 1'b0, core_stat_reg, 8'h00};
      end
      `TSM_IDX_IRQ_STAT: begin
        rdata_next = {30'h0000_0000, irq_stat_bits};
      end
      `TSM_IDX_IRQ_MASK: begin
        rdata_next = {30'h0000_0000, irq_mask_reg};
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // Next values of the configuration registers; only the addressed one moves.
  reg [3:0] period_next;
  reg [13:0] mode_hi_next;
  reg periodic_next;
  reg [15:0] thresh_next;
  reg [1:0] irq_mask_next;
  always @* begin
    period_next = period_reg;
    mode_hi_next = mode_hi_reg;
    periodic_next = periodic_reg;
    thresh_next = thresh_reg;
    irq_mask_next = irq_mask_reg;
    if (wr_period) begin
      period_next = hwdata[3:0];
    end
    if (wr_mode) begin
      mode_hi_next = hwdata[15:2];
      periodic_next = hwdata[1];
    end
    if (wr_thresh) begin
      thresh_next = hwdata[15:0];
    end
    if (wr_imask) begin
      irq_mask_next = hwdata[1:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 12'h000;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= take & hwrite;
      if (take) begin
        wr_idx_reg <= idx;
      end
      if (take & ~hwrite) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Configuration registers.
  always @(posedge clk) begin
    if (!rst_n) begin
      period_reg <= `TSM_RST_PERIOD;
      mode_hi_reg <= `TSM_RST_MODE_HI;
      periodic_reg <= 1'b1;
      thresh_reg <= `TSM_RST_THRESH;
      irq_mask_reg <= 2'b00;
    end else begin
      period_reg <= period_next;
      mode_hi_reg <= mode_hi_next;
      periodic_reg <= periodic_next;
      thresh_reg <= thresh_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // Millisecond divider: a one-cycle enable pulse that only runs during a wait,
  // so every wait starts from a whole millisecond.
  always @(posedge clk) begin
    if (!rst_n) begin
      ms_cnt_reg <= 32'h0000_0000;
    end else if (state_reg != ST_WAIT || ms_tick) begin
      ms_cnt_reg <= 32'h0000_0000;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
    end
  end

  // Run sequencer: start launches a run, periodic mode rearms after each one.
  // A start written during a run is kept and launches the next run when it ends.
  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      start_reg <= 1'b0;
      per_cnt_reg <= 8'h00;
      to_cnt_reg <= 8'h00;
    end else begin
      if (start_wr) begin
        start_reg <= 1'b1;
      end else if (start_reg && state_reg != ST_SAMPLE) begin
        start_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (start_reg) begin
            state_reg <= ST_SAMPLE;
            to_cnt_reg <= 8'h00;
          end
        end
        ST_SAMPLE: begin
          to_cnt_reg <= to_cnt_reg + 8'h01;
          if (run_done | run_timeout) begin
            per_cnt_reg <= 8'h00;
            state_reg <= periodic_reg ? ST_WAIT : ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (start_reg) begin
            state_reg <= ST_SAMPLE;
            to_cnt_reg <= 8'h00;
          end else if (!periodic_reg) begin
            state_reg <= ST_IDLE;
          end else if (ms_tick) begin
            if (per_cnt_reg == wait_ms - 8'h01) begin
              state_reg <= ST_SAMPLE;
              to_cnt_reg <= 8'h00;
            end else begin
              per_cnt_reg <= per_cnt_reg + 8'h01;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Status capture: bands are taken once per completed run, then held.
  always @(posedge clk) begin
    if (!rst_n) begin
      temp_stat_reg <= 3'b000;
      io_stat_reg <= 3'b000;
      core_stat_reg <= 3'b000;
    end else if (run_done) begin
      temp_stat_reg <= temp_sync;
      io_stat_reg <= io_sync;
      core_stat_reg <= core_sync;
    end
  end

  // Sticky events: bit 0 run complete, bit 1 run timeout.
  // A set wins over a write-one-to-clear in the same cycle, so no event is lost.
  wire [1:0] ev = {run_timeout & ~run_done, run_done};
  wire [1:0] ev_clr = wr_istat ? hwdata[1:0] : 2'b00;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq
      reg flag_reg;
      always @(posedge clk) begin
        if (!rst_n) begin
          flag_reg <= 1'b0;
        end else if (ev[gi]) begin
          flag_reg <= 1'b1;
        end else if (ev_clr[gi]) begin
          flag_reg <= 1'b0;
        end
      end
      assign irq_stat_bits[gi] = flag_reg;
    end
  endgenerate

  assign sample_req = (state_reg == ST_SAMPLE);
  assign uv_threshold = thresh_reg[14:12];
  assign ov_threshold = thresh_reg[10:8];
  assign ot_threshold = thresh_reg[2:0];
  assign irq = |(irq_stat_bits & irq_mask_reg);
  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule // tsm_ctrl
`default_nettype wire

// [bench/tsm_ctrl_asserts.sv]
// Port-level assertions for the monitor controller.
`timescale 1ns/1ns
`default_nettype none
module tsm_ctrl_asserts (
  input wire clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire sample_req,
  input wire sample_done,
  input wire [2:0] uv_threshold,
  input wire [2:0] ov_threshold,
  input wire [2:0] ot_threshold,
  input wire irq
);
  wire acc = hsel && htrans[1] && hreadyout;
  reg wr_t, wr_m, wr_k;
  reg [31:0] d_q;
  // Write flags mark the data phase, where hwdata is valid.
  always @(posedge clk) begin
    wr_t <= acc && hwrite && haddr == 32'h0000_1208;
    wr_m <= acc && hwrite && haddr == 32'h0000_1204;
    wr_k <= acc && hwrite && haddr == 32'h0000_1244;
    d_q <= hwdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_thresh_out: assert property (wr_t |-> ##[1:2]
    {uv_threshold, ov_threshold, ot_threshold} == {d_q[14:12], d_q[10:8], d_q[2:0]})
    else $error("threshold outputs differ from write");
  a_start_run: assert property (wr_m && hwdata[0] |-> ##[1:4] sample_req)
    else $error("start did not launch a run");
  a_zero_start: assert property (wr_m && hwdata[1:0] == 2'h0 && !sample_req
    |=> !sample_req [*4]) else $error("writing zero launched a run");
  a_run_bound: assert property ($rose(sample_req) |-> ##[1:300] !sample_req)
    else $error("run never ended");
  a_done_ends: assert property (sample_req && $rose(sample_done)
    |-> ##[1:6] !sample_req) else $error("run outlived done");
  a_mask_off: assert property (wr_k && hwdata[1:0] == 2'h0 |-> ##3 !irq)
    else $error("masked interrupt still high");
  a_rdata_hold: assert property (!(acc && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  c_run: cover property ($rose(sample_req));
  c_irq: cover property ($rose(irq));
  c_rd_temp: cover property (acc && !hwrite && haddr == 32'h0000_120C);
endmodule // tsm_ctrl_asserts
bind tsm_ctrl tsm_ctrl_asserts u_chk (.*);
`default_nettype wire

// [bench/tsm_ctrl_tb.sv]
// Self-checking bench for the monitor controller.
`timescale 1ns/1ns
`default_nettype none
module tsm_ctrl_tb;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, sample_done = 0, chk = 0;
  logic [31:0] haddr = 0, hwdata = 0, v;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, temp_band = 0, io_supply_rail_band = 0, core_supply_band = 0;
  wire [31:0] hrdata;
  wire [2:0] uv_threshold, ov_threshold, ot_threshold;
  wire hreadyout, hresp, sample_req, irq;
  wire hready = hreadyout;
  int n_fail = 0, num_checks = 0, cyc = 0, n;
  logic [31:0] q[$];
  // A short millisecond keeps the periodic wait at 64 cycles.
  tsm_ctrl #(.MS_CYCLES(4)) DUT (.*);
  initial forever #4 clk = ~clk;
  task cmp(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) if (chk) cmp("hrdata", q.pop_front(), hrdata);
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      wrap_up;
    end
  end
  // For a read, d is the expected word rather than data to send.
  task xfer(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hready !== 1);
    htrans <= 0;
    hsel <= 0;
    hwdata <= d;
    chk <= !w;
    if (!w) q.push_back(d);
    do @(posedge clk); while (hready !== 1);
    chk <= 0;
  endtask
  task wreq(input logic l);
    for (n = 0; n < 400 && sample_req !== l; n++) @(posedge clk);
  endtask
  initial begin
    v = $urandom(1);
    repeat (10) @(posedge clk);
    rst_n <= 1;
    xfer(0, 32'h0000_1200, 32'h0000_0002);
    xfer(0, 32'h0000_1204, 32'h0000_00A2);
    xfer(0, 32'h0000_1208, 32'h0000_7007);
    xfer(0, 32'h0000_120C, 32'h0000_0000);
    xfer(0, 32'h0000_1300, 32'h0000_0000);
    v = $urandom & 32'h0000_FFFF;
    xfer(1, 32'h0000_1208, v);
    xfer(0, 32'h0000_1208, v);
    temp_band <= $urandom;
    io_supply_rail_band <= $urandom;
    core_supply_band <= $urandom;
    xfer(1, 32'h0000_1204, 32'h0000_00A1);
    wreq(1);
    cmp("sample_req", 1, sample_req);
    sample_done <= 1;
    wreq(0);
    sample_done <= 0;
    xfer(1, 32'h0000_120C, 32'h0000_0007);
    xfer(0, 32'h0000_120C, {29'h0, temp_band});
    xfer(0, 32'h0000_1210, {17'h0, io_supply_rail_band, 1'b0, core_supply_band, 8'h0});
    xfer(0, 32'h0000_1204, 32'h0000_00A0);
    v = temp_band;
    temp_band <= ~temp_band;
    repeat (40) @(posedge clk);
    cmp("sample_req", 0, sample_req);
    xfer(0, 32'h0000_120C, v);
    xfer(0, 32'h0000_1240, 32'h0000_0001);
    xfer(1, 32'h0000_1244, 32'h0000_0003);
    repeat (2) @(posedge clk);
    cmp("irq", 1, irq);
    xfer(1, 32'h0000_1240, 32'h0000_0001);
    repeat (2) @(posedge clk);
    cmp("irq", 0, irq);
    xfer(1, 32'h0000_1200, 32'h0000_0001);
    xfer(1, 32'h0000_1204, 32'h0000_00A3);
    wreq(1);
    sample_done <= 1;
    wreq(0);
    sample_done <= 0;
    wreq(1);
    cmp("period", 1, n > 58 && n < 72);
    wreq(0);
    xfer(0, 32'h0000_1240, 32'h0000_0003);
    xfer(1, 32'h0000_1204, 32'h0000_00A0);
    xfer(1, 32'h0000_1244, 32'h0000_0000);
    repeat (4) @(posedge clk);
    wrap_up;
  end
endmodule // tsm_ctrl_tb
`default_nettype wire
